// ===== pkg/lin_wd_pkg.sv
package lin_wd_pkg;

    // clock rate in MHz; cycle counts derive from it
    localparam int CLK_MHZ           = 100;

    // watchdog frame lengths, in microseconds, per window-select level
    localparam int FRAME_SHORT_US    = 32000;
    localparam int FRAME_MID_US      = 480000;
    localparam int FRAME_LONG_US     = 4800000;
    // trigger_filter_time, reset_pulse_time, dominant_limit_time
    localparam int TRIG_FILTER_US    = 10;
    localparam int RESET_PULSE_US    = 1000;
    localparam int DOMINANT_LIMIT_US = 20000;

    localparam int TRIG_FILTER_CYC   = TRIG_FILTER_US * CLK_MHZ;

    // window-select input levels
    localparam logic [1:0] WSEL_GROUND = 2'h0;
    localparam logic [1:0] WSEL_SUPPLY = 2'h1;

    // serial frame: address byte then data byte, msb first
    localparam int          SPI_FRAME_BITS    = 16;
    localparam logic [7:0]  WATCHDOG_RESTART  = 8'h15;
    localparam logic [7:0]  RESTART_KEY       = 8'hFF;

    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_RUN   = 2'b01,
        WD_PULSE = 2'b10
    } wd_state_t;

    typedef enum logic [1:0] {
        OP_SLEEP   = 2'b00,
        OP_STANDBY = 2'b01,
        OP_NORMAL  = 2'b10
    } op_mode_t;

    typedef struct packed {
        logic        busOe;
        logic        busOut;
        logic        rxdOut;
        logic        uvResetOut;
        logic        wdResetOut;
        logic        intOut;
        logic        intOe;
    } pins_t;

    typedef struct packed {
        logic        strapped;
        logic        spiMode;
        wd_state_t   wdState;
        logic [31:0] wdCount;
        logic [31:0] frameLen;
        logic        trigLevel;
        logic [15:0] trigCount;
        op_mode_t    opMode;
        logic        busLock;
        logic        busWake;
        logic        wakePrev;
        logic        txdPrev;
        logic        dtoFault;
        logic [31:0] dtoCount;
        logic        sckPrev;
        logic [4:0]  spiBits;
        logic [15:0] spiShift;
        pins_t       pins;
    } state_t;

    localparam pins_t PINS_RESET = '{
        busOe: 1'b0, busOut: 1'b0, rxdOut: 1'b1, uvResetOut: 1'b0,
        wdResetOut: 1'b1, intOut: 1'b0, intOe: 1'b0
    };

    localparam state_t STATE_RESET = '{
        strapped: 1'b0, spiMode: 1'b0, wdState: WD_IDLE, wdCount: 32'h0,
        frameLen: 32'h0, trigLevel: 1'b0, trigCount: 16'h0,
        opMode: OP_STANDBY, busLock: 1'b0, busWake: 1'b0, wakePrev: 1'b0,
        txdPrev: 1'b1, dtoFault: 1'b0, dtoCount: 32'h0, sckPrev: 1'b0,
        spiBits: 5'h0, spiShift: 16'h0, pins: PINS_RESET
    };

endpackage : lin_wd_pkg

// ===== hdl/lin_window_watchdog_control.sv
`timescale 1ns/1ps

module lin_window_watchdog_control #(
    parameter int FRAME_SHORT_CYC    = lin_wd_pkg::FRAME_SHORT_US * lin_wd_pkg::CLK_MHZ,
    parameter int FRAME_MID_CYC      = lin_wd_pkg::FRAME_MID_US * lin_wd_pkg::CLK_MHZ,
    parameter int FRAME_LONG_CYC     = lin_wd_pkg::FRAME_LONG_US * lin_wd_pkg::CLK_MHZ,
    parameter int RESET_PULSE_CYC    = lin_wd_pkg::RESET_PULSE_US * lin_wd_pkg::CLK_MHZ,
    parameter int DOMINANT_LIMIT_CYC = lin_wd_pkg::DOMINANT_LIMIT_US * lin_wd_pkg::CLK_MHZ
) (
    input  wire logic       sys_clk,
    input  wire logic       undervoltage_reset_output,
    input  wire logic       controlSelectPin,
    input  wire logic [1:0] windowSelectInput,
    input  wire logic       watchdogTriggerInput,
    input  wire logic       txd,
    input  wire logic       busIn,
    input  wire logic       localWakeup,
    input  wire logic       thermalShutdown,
    input  wire logic       supplyAboveThreshold,
    input  wire logic       enableIn,
    output logic            busOut,
    output logic            busOe,
    output logic            rxd,
    output logic            undervoltageResetOut,
    output logic            watchdogResetOut,
    output logic            enableOut,
    output logic            enableOe
);

    lin_wd_pkg::state_t state;
    lin_wd_pkg::state_t next_state;

    logic        pinTrig;
    logic        spiTrig;
    logic        trigger;
    logic        sckRise;
    logic [15:0] frameShifted;
    logic        pulseNext;

    always_comb begin
        next_state   = state;
        pinTrig      = 1'b0;
        spiTrig      = 1'b0;
        trigger      = 1'b0;
        sckRise      = 1'b0;
        frameShifted = 16'h0;
        pulseNext    = 1'b0;

        // latch control method and frame length once after reset release
        if (!state.strapped) begin
            next_state.strapped = 1'b1;
            next_state.spiMode  = controlSelectPin;
            // a trigger pin that sits high out of reset is a level, not an edge
            next_state.trigLevel = watchdogTriggerInput;
            if (controlSelectPin) begin
                next_state.frameLen = 32'(FRAME_LONG_CYC);
            end else if (windowSelectInput == lin_wd_pkg::WSEL_GROUND) begin
                next_state.frameLen = 32'(FRAME_SHORT_CYC);
            end else if (windowSelectInput == lin_wd_pkg::WSEL_SUPPLY) begin
                next_state.frameLen = 32'(FRAME_MID_CYC);
            end else begin
                next_state.frameLen = 32'(FRAME_LONG_CYC);
            end
        end

        // trigger input glitch filter: a new level must hold for the filter time
        if (watchdogTriggerInput != state.trigLevel) begin
            if (state.trigCount >= 16'(lin_wd_pkg::TRIG_FILTER_CYC - 1)) begin
                next_state.trigLevel = watchdogTriggerInput;
                next_state.trigCount = 16'h0;
                pinTrig              = state.strapped && !state.spiMode;
            end else begin
                next_state.trigCount = state.trigCount + 16'h1;
            end
        end else begin
            next_state.trigCount = 16'h0;
        end

        // serial write path; clock and data share the window-select and trigger pins
        next_state.sckPrev = windowSelectInput[0];
        sckRise            = windowSelectInput[0] && !state.sckPrev;
        if (!state.spiMode || controlSelectPin) begin
            next_state.spiBits = 5'h0;
        end else if (sckRise) begin
            frameShifted        = {state.spiShift[14:0], watchdogTriggerInput};
            next_state.spiShift = frameShifted;
            if (state.spiBits == 5'(lin_wd_pkg::SPI_FRAME_BITS - 1)) begin
                next_state.spiBits = 5'h0;
                spiTrig = (frameShifted[15:8] == lin_wd_pkg::WATCHDOG_RESTART)
                       && (frameShifted[7:0] == lin_wd_pkg::RESTART_KEY);
            end else begin
                next_state.spiBits = state.spiBits + 5'h1;
            end
        end

        trigger = state.spiMode ? spiTrig : pinTrig;

        unique case (state.wdState)
            lin_wd_pkg::WD_IDLE: begin
                if (trigger) begin
                    next_state.wdState = lin_wd_pkg::WD_RUN;
                    next_state.wdCount = 32'h0;
                end
            end
            lin_wd_pkg::WD_RUN: begin
                next_state.wdCount = state.wdCount + 32'h1;
                if (trigger && state.wdCount < (state.frameLen >> 1)) begin
                    next_state.wdState = lin_wd_pkg::WD_PULSE;
                    next_state.wdCount = 32'h0;
                end else if (trigger) begin
                    next_state.wdCount = 32'h0;
                end else if (state.wdCount >= state.frameLen - 32'h1) begin
                    next_state.wdState = lin_wd_pkg::WD_PULSE;
                    next_state.wdCount = 32'h0;
                end
            end
            lin_wd_pkg::WD_PULSE: begin
                next_state.wdCount = state.wdCount + 32'h1;
                if (state.wdCount >= 32'(RESET_PULSE_CYC - 1)) begin
                    next_state.wdState = lin_wd_pkg::WD_IDLE;
                    next_state.wdCount = 32'h0;
                end
            end
            default: begin
                next_state.wdState = lin_wd_pkg::WD_IDLE;
                next_state.wdCount = 32'h0;
            end
        endcase
        pulseNext = (next_state.wdState == lin_wd_pkg::WD_PULSE);

        // operating mode; serial mode has no enable input and stays normal
        next_state.wakePrev = localWakeup;
        if (state.spiMode) begin
            next_state.opMode  = lin_wd_pkg::OP_NORMAL;
            next_state.busWake = 1'b0;
        end else begin
            unique case (state.opMode)
                lin_wd_pkg::OP_NORMAL: begin
                    if (!enableIn) begin
                        next_state.opMode  = lin_wd_pkg::OP_SLEEP;
                        next_state.busLock = !busIn;
                    end
                end
                lin_wd_pkg::OP_SLEEP: begin
                    // a bus already dominant on entry must go recessive before it can wake
                    if (state.busLock && busIn) begin
                        next_state.busLock = 1'b0;
                    end
                    if (enableIn) begin
                        next_state.opMode = lin_wd_pkg::OP_NORMAL;
                    end else if (localWakeup != state.wakePrev) begin
                        next_state.opMode = lin_wd_pkg::OP_STANDBY;
                    end else if (!state.busLock && !busIn) begin
                        next_state.opMode  = lin_wd_pkg::OP_STANDBY;
                        next_state.busWake = 1'b1;
                    end
                end
                lin_wd_pkg::OP_STANDBY: begin
                    if (enableIn) begin
                        next_state.opMode  = lin_wd_pkg::OP_NORMAL;
                        next_state.busWake = 1'b0;
                    end
                end
                default: begin
                    next_state.opMode = lin_wd_pkg::OP_STANDBY;
                end
            endcase
        end

        // dominant timeout on the transmit input
        next_state.txdPrev = txd;
        if (txd && !state.txdPrev) begin
            next_state.dtoFault = 1'b0;
            next_state.dtoCount = 32'h0;
        end else if (!txd && state.txdPrev) begin
            next_state.dtoCount = 32'h0;
        end else if (!txd && !state.dtoFault
                     && state.opMode == lin_wd_pkg::OP_NORMAL) begin
            next_state.dtoCount = state.dtoCount + 32'h1;
            if (state.dtoCount >= 32'(DOMINANT_LIMIT_CYC - 1)) begin
                next_state.dtoFault = 1'b1;
            end
        end

        // pin outputs, all registered
        next_state.pins.busOut = 1'b0;
        next_state.pins.busOe  = (next_state.opMode == lin_wd_pkg::OP_NORMAL) && !txd
                              && !next_state.dtoFault && !thermalShutdown;
        unique case (next_state.opMode)
            lin_wd_pkg::OP_NORMAL:  next_state.pins.rxdOut = busIn;
            lin_wd_pkg::OP_STANDBY: next_state.pins.rxdOut = !next_state.busWake;
            default:                next_state.pins.rxdOut = 1'b1;
        endcase
        if (next_state.spiMode) begin
            next_state.pins.uvResetOut = supplyAboveThreshold && !thermalShutdown
                                      && !pulseNext;
            next_state.pins.wdResetOut = 1'b1;
            next_state.pins.intOut     = 1'b0;
            next_state.pins.intOe      = next_state.dtoFault || thermalShutdown;
        end else begin
            next_state.pins.uvResetOut = supplyAboveThreshold && !thermalShutdown;
            next_state.pins.wdResetOut = !pulseNext;
            next_state.pins.intOut     = 1'b0;
            next_state.pins.intOe      = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge undervoltage_reset_output) begin
        if (!undervoltage_reset_output) begin
            state <= lin_wd_pkg::STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign busOut               = state.pins.busOut;
    assign busOe                = state.pins.busOe;
    assign rxd                  = state.pins.rxdOut;
    assign undervoltageResetOut = state.pins.uvResetOut;
    assign watchdogResetOut     = state.pins.wdResetOut;
    assign enableOut            = state.pins.intOut;
    assign enableOe             = state.pins.intOe;

endmodule : lin_window_watchdog_control

// ===== verification/lin_wd_assertions.sv
`timescale 1ns/1ps
module lin_wd_assertions #(
    parameter int RESET_PULSE_CYC    = 20,
    parameter int DOMINANT_LIMIT_CYC = 50
) (
    input wire logic sys_clk,
    input wire logic undervoltage_reset_output,
    input wire logic controlSelectPin,
    input wire logic txd,
    input wire logic thermalShutdown,
    input wire logic supplyAboveThreshold,
    input wire logic busOe,
    input wire logic undervoltageResetOut,
    input wire logic watchdogResetOut,
    input wire logic enableOe
);
    logic [1:0]  age;
    logic        spi;
    logic [31:0] lowRun;
    logic [31:0] txdLow;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!undervoltage_reset_output);
    // mode is latched on the first edge after reset; outputs are trusted from the fourth
    always_ff @(posedge sys_clk or negedge undervoltage_reset_output) begin
        if (!undervoltage_reset_output) begin
            age    <= 2'h0;
            spi    <= 1'b0;
            lowRun <= 32'h0;
            txdLow <= 32'h0;
        end else begin
            spi    <= (age == 2'h0) ? controlSelectPin : spi;
            age    <= (age == 2'h3) ? age : age + 2'h1;
            lowRun <= watchdogResetOut ? 32'h0 : lowRun + 32'h1;
            txdLow <= txd ? 32'h0 : txdLow + 32'h1;
        end
    end
    property p_txd_dom; busOe |-> !$past(txd); endproperty
    a_txd_dom: assert property (p_txd_dom) else $error("bus driven with transmit high");
    property p_hot_off; $past(thermalShutdown) |-> !busOe; endproperty
    a_hot_off: assert property (p_hot_off) else $error("bus driven while hot");
    property p_dto; txdLow > DOMINANT_LIMIT_CYC + 2 |-> !busOe; endproperty
    a_dto: assert property (p_dto) else $error("stuck dominant not cut");
    property p_pulse; $rose(watchdogResetOut) |-> lowRun == RESET_PULSE_CYC; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
    property p_spi_wdr; age == 2'h3 && spi |-> watchdogResetOut; endproperty
    a_spi_wdr: assert property (p_spi_wdr) else $error("pin reset used in serial mode");
    property p_pin_int; age == 2'h3 && !spi |-> !enableOe; endproperty
    a_pin_int: assert property (p_pin_int) else $error("interrupt driven in pin mode");
    property p_spi_int; age == 2'h3 && spi && $past(thermalShutdown) |-> enableOe; endproperty
    a_spi_int: assert property (p_spi_int) else $error("interrupt missing when hot");
    property p_uv_pin;
        age == 2'h3 && !spi |->
            undervoltageResetOut == ($past(supplyAboveThreshold) && !$past(thermalShutdown));
    endproperty
    a_uv_pin: assert property (p_uv_pin) else $error("supply reset wrong in pin mode");
endmodule : lin_wd_assertions

bind lin_window_watchdog_control lin_wd_assertions #(
    .RESET_PULSE_CYC(RESET_PULSE_CYC),
    .DOMINANT_LIMIT_CYC(DOMINANT_LIMIT_CYC)
) chk (
    .sys_clk, .undervoltage_reset_output, .controlSelectPin, .txd, .thermalShutdown, .supplyAboveThreshold,
    .busOe, .undervoltageResetOut, .watchdogResetOut, .enableOe
);

// ===== verification/lin_host_model.sv
`timescale 1ns/1ps
module lin_host_model (
    input  wire logic       sys_clk,
    output logic            csN,
    output logic [1:0]      wsel,
    output logic            sdi,
    output logic            txd,
    output logic            en
);
    // msb first; each serial clock half period spans two system cycles
    task automatic spi_write(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] word;
        word = {addr, data};
        csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = word[i];
            repeat (2) @(negedge sys_clk);
            wsel[0] = 1'b1;
            repeat (2) @(negedge sys_clk);
            wsel[0] = 1'b0;
        end
        repeat (2) @(negedge sys_clk);
        csN = 1'b1;
        sdi = ~sdi;
        // keep chip select high for a cycle so back-to-back frames stay apart
        @(negedge sys_clk);
    endtask : spi_write
endmodule : lin_host_model

// ===== verification/lin_window_watchdog_control_tb.sv
`timescale 1ns/1ps
module lin_window_watchdog_control_tb;
    localparam int PULSE = 20;
    logic       sys_clk, undervoltage_reset_output, busExt, localWakeup, thermalShutdown, supplyAboveThreshold;
    logic       busOe, busOut, rxd, uvOut, wdOut, enableOut, enableOe;
    wire        busIn, enableIn, csN, sdi, txd, en;
    wire  [1:0] wsel;
    int         errors, total_checks;
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    // open-drain bus: a released line is pulled up; a released enable line follows the host
    assign busIn    = busExt & ~(busOe & ~busOut);
    assign enableIn = enableOe ? enableOut : en;
    lin_host_model host (.sys_clk, .csN, .wsel, .sdi, .txd, .en);
    lin_window_watchdog_control #(
        .FRAME_SHORT_CYC(4000), .FRAME_MID_CYC(6000), .FRAME_LONG_CYC(8000),
        .RESET_PULSE_CYC(PULSE), .DOMINANT_LIMIT_CYC(50)
    ) uut (
        .sys_clk, .undervoltage_reset_output, .controlSelectPin(csN), .windowSelectInput(wsel),
        .watchdogTriggerInput(sdi), .txd, .busIn, .localWakeup, .thermalShutdown,
        .supplyAboveThreshold, .enableIn, .busOut, .busOe, .rxd,
        .undervoltageResetOut(uvOut), .watchdogResetOut(wdOut), .enableOut, .enableOe
    );
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic complete_run();
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    task automatic reset_dut(input logic strap, input logic [1:0] sel);
        undervoltage_reset_output      = 1'b0;
        host.csN  = strap;
        host.wsel = sel;
        host.sdi  = 1'b0;
        tick(2);
        undervoltage_reset_output = 1'b1;
        tick(4);
    endtask : reset_dut
    task automatic flip(input int n);
        host.sdi = ~host.sdi;
        tick(n);
    endtask : flip
    // a reset output must fall within [lo, hi) cycles; lo == hi means not at all
    task automatic ev(input logic uv, input int lo, input int hi);
        int n;
        n = 0;
        while (n < hi && (uv ? uvOut : wdOut) !== 1'b0) begin
            tick(1);
            n++;
        end
        check("reset delay", n >= lo && (n < hi || lo == hi), 1'b1);
        if (n < lo || (n == hi && lo != hi)) complete_run();
    endtask : ev
    task automatic pulse(input logic uv);
        int n;
        n = 0;
        while (n < 99 && (uv ? uvOut : wdOut) === 1'b0) begin
            tick(1);
            n++;
        end
        check("pulse length", n == PULSE, 1'b1);
        if (n == 99) complete_run();
    endtask : pulse
    task automatic t_paths();
        reset_dut(1'b0, 2'h0);
        check("uv out", uvOut, 1'b1);
        supplyAboveThreshold = 1'b0;
        tick(2);
        check("uv out low", uvOut, 1'b0);
        supplyAboveThreshold = 1'b1;
        tick(2);
        check("uv out back", uvOut, 1'b1);
        host.en = 1'b1;
        tick(4);
        host.txd = 1'b0;
        tick(2);
        check("bus oe", busOe, 1'b1);
        check("bus out", busOut, 1'b0);
        check("rxd dominant", rxd, 1'b0);
        thermalShutdown = 1'b1;
        tick(2);
        check("bus oe hot", busOe, 1'b0);
        thermalShutdown = 1'b0;
        tick(60);
        check("bus oe stuck", busOe, 1'b0);
        host.txd = 1'b1;
        tick(2);
        check("rxd recessive", rxd, 1'b1);
        host.txd = 1'b0;
        tick(2);
        check("bus oe cleared", busOe, 1'b1);
        host.txd = 1'b1;
        host.en  = 1'b0;
        tick(4);
        host.txd = 1'b0;
        tick(2);
        check("bus oe sleep", busOe, 1'b0);
        host.txd = 1'b1;
        busExt   = 1'b0;
        tick(4);
        busExt = 1'b1;
        tick(4);
        check("rxd bus wake", rxd, 1'b0);
        host.en = 1'b1;
        tick(4);
        check("rxd normal", rxd, 1'b1);
        host.en = 1'b0;
        tick(4);
        localWakeup = 1'b1;
        tick(4);
        // standby ignores the bus; a device still asleep would flag a bus wake
        busExt = 1'b0;
        tick(4);
        check("rxd local wake", rxd, 1'b1);
        busExt = 1'b1;
        tick(2);
    endtask : t_paths
    task automatic t_wd_pin();
        reset_dut(1'b0, 2'h0);
        flip(500);
        host.sdi = ~host.sdi;
        ev(1'b0, 6000, 6000);
        flip(1500);
        host.sdi = ~host.sdi;
        ev(1'b0, 995, 1010);
        pulse(1'b0);
        flip(3000);
        host.sdi = ~host.sdi;
        ev(1'b0, 4995, 5010);
        pulse(1'b0);
    endtask : t_wd_pin
    task automatic t_frames();
        int f;
        for (int s = 1; s < 4; s++) begin
            f = (s == 1) ? 6000 : 8000;
            reset_dut(1'b0, 2'(s));
            host.sdi = ~host.sdi;
            ev(1'b0, f + 995, f + 1010);
        end
    endtask : t_frames
    task automatic t_serial();
        reset_dut(1'b1, 2'h0);
        host.en = 1'b1;
        host.spi_write(8'h15, 8'hFE);
        host.spi_write(8'h14, 8'hFF);
        host.spi_write(8'h15, 8'hFF);
        ev(1'b1, 5000, 5000);
        host.spi_write(8'h15, 8'hFF);
        ev(1'b1, 7985, 8010);
        pulse(1'b1);
        check("interrupt idle", enableIn, 1'b1);
        thermalShutdown = 1'b1;
        tick(3);
        check("interrupt pin", enableIn, 1'b0);
        thermalShutdown = 1'b0;
    endtask : t_serial
    initial begin
        errors               = 0;
        total_checks         = 0;
        busExt               = 1'b1;
        localWakeup          = 1'b0;
        thermalShutdown      = 1'b0;
        supplyAboveThreshold = 1'b1;
        host.txd             = 1'b1;
        host.en              = 1'b0;
        t_paths();
        t_wd_pin();
        t_frames();
        t_serial();
        complete_run();
    end
endmodule : lin_window_watchdog_control_tb
